// >>> core/ncis_core.sv
// Nibble core executing the skip, bank, return, stop, vector and exchange group
`timescale 1ns/1ps
//
// Contract
// - Subtract skips on borrow, carry untouched.
// - Set carry forces carry, one cycle.
// - Memory bank operand becomes top address nibble.
// - Banks 0, 1, 15 map work, display, I/O.
// - Memory bank select needs memory bank enable.
// - Register bank select picks one of four.
// - Register bank enable low forces bank zero.
// - Each register bank spans eight nibbles.
// - Return-and-skip pops frame, SP plus six, skips.
// - Frame holds PC nibbles and enable flags.
// - Stop sets power control bit three.
// - Stop mode halts all core activity; the code stops only the sequencer, port and request wake stay live.
// - Stop is two bytes, two cycles.
// - Reset or vector loads PC and flags.
// - Interrupt pushes flags, interrupt return restores.
// - Accumulator register exchange, one byte, one cycle.
// - Byte exchange with pointer memory, two cycles.
// - Stop writes power control stop bit.
module ncis_core (
  input wire logic ref_clk,
  input wire logic resetn,
  output logic [12:0] pm_addr,
  output logic pm_rd,
  input wire logic [7:0] pm_data,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  output logic stop_mode
);
  ncis_pkg::ncis_state_type state;
  ncis_pkg::ncis_state_type pm_ret;
  ncis_pkg::ncis_cls_type cls;
  ncis_pkg::ncis_src_type src_mode;
  logic [12:0] pc;
  logic [7:0] sp;
  logic carry;
  logic mem_bank_en;
  logic reg_bank_en;
  logic [3:0] mem_bank;
  logic [1:0] reg_bank;
  logic [3:0] power_control_reg;
  logic skip;
  logic [7:0] op1;
  logic [7:0] op2;
  logic [2:0] k;
  logic [3:0] t [0:5];
  logic [3:0] w [0:3];
  logic [3:0] wmask;
  logic [4:0] mc_div;
  logic [1:0] cyc_cnt;
  logic [1:0] need;
  logic [2:0] vec_idx;
  logic [7:0] vec_hi;
  logic hold;
  logic vreq_pend;
  logic [2:0] vreq_idx;
  logic rd_ram_q;
  logic rd_power_control_reg_q;

  ncis_ram_if ram_bus();

  ncis_ram u_ram (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .bus(ram_bus)
  );

  // Decode of the held opcode bytes
  wire logic two_byte_in = pm_data == ncis_pkg::OP_PFX_DC || pm_data == ncis_pkg::OP_PFX_DD ||
                           pm_data == ncis_pkg::OP_PFX_FF;
  wire logic pfx_dc = op1 == ncis_pkg::OP_PFX_DC;
  wire logic pfx_dd = op1 == ncis_pkg::OP_PFX_DD;
  wire logic pfx_ff = op1 == ncis_pkg::OP_PFX_FF;
  wire logic two_byte_op = pfx_dc || pfx_dd || pfx_ff;
  assign cls =
    (op1 == ncis_pkg::OP_SBS_AM) ? ncis_pkg::CLS_SBS_AM :
    (op1 == ncis_pkg::OP_SCF) ? ncis_pkg::CLS_SCF :
    (op1 == ncis_pkg::OP_RETURN_AND_SKIP_OP) ? ncis_pkg::CLS_RETURN_AND_SKIP_OP :
    (op1 == ncis_pkg::OP_RET) ? ncis_pkg::CLS_RET :
    (op1 == ncis_pkg::OP_INTERRUPT_RETURN_OP) ? ncis_pkg::CLS_INTERRUPT_RETURN_OP :
    (op1[7:3] == ncis_pkg::OP_XCH_AR_HI) ? ncis_pkg::CLS_XCH_AR :
    (pfx_dc && op2[7:3] == ncis_pkg::OP2_SBS_EARR && !op2[0]) ? ncis_pkg::CLS_SBS_EARR :
    (pfx_dc && op2[7:3] == ncis_pkg::OP2_SBS_RREA && !op2[0]) ? ncis_pkg::CLS_SBS_RREA :
    (pfx_dc && op2 == ncis_pkg::OP2_XCH_EAHL) ? ncis_pkg::CLS_XCH_EAHL :
    (pfx_dd && op2[7:4] == ncis_pkg::OP2_SMB_HI) ? ncis_pkg::CLS_SMB :
    (pfx_dd && op2[7:2] == ncis_pkg::OP2_SRB_HI) ? ncis_pkg::CLS_SRB :
    (pfx_ff && op2 == ncis_pkg::OP2_STOP) ? ncis_pkg::CLS_STOP : ncis_pkg::CLS_NOP;
  wire logic is_pop = cls == ncis_pkg::CLS_RET || cls == ncis_pkg::CLS_RETURN_AND_SKIP_OP ||
                      cls == ncis_pkg::CLS_INTERRUPT_RETURN_OP;
  assign src_mode =
    (cls == ncis_pkg::CLS_SBS_EARR || cls == ncis_pkg::CLS_SBS_RREA) ? ncis_pkg::SRC_PAIR :
    (cls == ncis_pkg::CLS_XCH_AR) ? ncis_pkg::SRC_REG : ncis_pkg::SRC_HL;
  wire logic [2:0] sel_n = (cls == ncis_pkg::CLS_XCH_AR) ? op1[2:0] : op2[2:0];

  // Skipped instructions cost only their byte count
  wire logic [1:0] bytes_op = two_byte_op ? 2'h2 : 2'h1;
  wire logic [1:0] cyc_need = skip ? bytes_op : (is_pop ? 2'h3 : bytes_op);

  // Data address generation
  wire logic [1:0] eff_rbank = reg_bank_en ? reg_bank : 2'h0;
  wire logic [3:0] dbank = mem_bank_en ? mem_bank : 4'h0;
  wire logic [2:0] acc_idx = (state == ncis_pkg::ST_WRITE) ? 3'(k + 3'h2) : k;
  wire logic use_stack = state == ncis_pkg::ST_PUSH || (state == ncis_pkg::ST_READ && is_pop);
  wire logic [7:0] stack_base = (state == ncis_pkg::ST_PUSH) ? 8'(sp - ncis_pkg::FRAME_NIBS) : sp;
  wire logic [7:0] stk_ptr = 8'(stack_base + {5'h00, acc_idx});
  wire logic [7:0] hl = {t[1], t[0]};
  wire logic [7:0] hl_next = 8'(hl + 8'h01);
  wire logic [2:0] src_lo_r = (src_mode == ncis_pkg::SRC_PAIR) ? {sel_n[2:1], 1'b0} : sel_n;
  wire logic [2:0] src_hi_r = {sel_n[2:1], 1'b1};
  wire logic src_is_mem = src_mode == ncis_pkg::SRC_HL;

  function automatic logic [11:0] regloc(input logic [1:0] bank, input logic [2:0] r);
    regloc = {7'h00, bank, r};
  endfunction

  wire logic [11:0] data_addr =
    use_stack ? {4'h0, stk_ptr} :
    (acc_idx == 3'h0) ? regloc(eff_rbank, ncis_pkg::RI_L) :
    (acc_idx == 3'h1) ? regloc(eff_rbank, ncis_pkg::RI_H) :
    (acc_idx == 3'h2) ? regloc(eff_rbank, ncis_pkg::RI_A) :
    (acc_idx == 3'h3) ? regloc(eff_rbank, ncis_pkg::RI_E) :
    (acc_idx == 3'h4) ? (src_is_mem ? {dbank, hl} : regloc(eff_rbank, src_lo_r)) :
    (acc_idx == 3'h5) ? (src_is_mem ? {dbank, hl_next} : regloc(eff_rbank, src_hi_r)) :
    12'h000;
  // Only banks 0 and 1 are backed by memory; bank 15 holds the power control nibble
  wire logic ram_hit = data_addr[11:9] == 3'h0;
  wire logic power_control_reg_hit = data_addr == ncis_pkg::POWER_CONTROL_REG_ADDR;

  wire logic [3:0] push_nib =
    (k == 3'h0) ? pc[11:8] :
    (k == 3'h2) ? pc[3:0] :
    (k == 3'h3) ? pc[7:4] :
    (k == 3'h4) ? {2'h0, mem_bank_en, reg_bank_en} : 4'h0;
  wire logic wr_now = state == ncis_pkg::ST_WRITE && wmask[k[1:0]];
  assign ram_bus.addr = data_addr[ncis_pkg::RAM_AW-1:0];
  assign ram_bus.we = ram_hit && (wr_now || state == ncis_pkg::ST_PUSH);
  assign ram_bus.wdata = (state == ncis_pkg::ST_PUSH) ? push_nib : w[k[1:0]];
  wire logic [3:0] rd_data = rd_ram_q ? ram_bus.rdata : (rd_power_control_reg_q ? power_control_reg : 4'h0);

  // Arithmetic of the subtract-and-skip forms
  wire logic [4:0] diff_am = 5'({1'b0, t[2]} - {1'b0, t[4]});
  wire logic [8:0] diff_earr = 9'({1'b0, t[3], t[2]} - {1'b0, t[5], t[4]});
  wire logic [8:0] diff_rrea = 9'({1'b0, t[5], t[4]} - {1'b0, t[3], t[2]});

  wire logic mc_tick = mc_div == ncis_pkg::MC_LAST;
  wire logic wait_done = mc_tick && cyc_cnt == 2'(need - 2'h1);
  wire logic take_irq = state == ncis_pkg::ST_FETCH && !hold && vreq_pend;
  wire logic exec_stop = state == ncis_pkg::ST_EXEC && cls == ncis_pkg::CLS_STOP;
  wire logic sw_ctrl_wr = reg_wr && reg_addr == ncis_pkg::REG_CTRL;
  wire logic sw_vreq_wr = reg_wr && reg_addr == ncis_pkg::REG_VREQ;
  wire logic sw_power_control_reg_wr = reg_wr && reg_addr == ncis_pkg::REG_POWER_CONTROL_REG;
  wire logic [7:0] reg_rd_val =
    (reg_addr == ncis_pkg::REG_CTRL) ? {7'h00, hold} :
    (reg_addr == ncis_pkg::REG_VREQ) ? {4'h0, vreq_pend, vreq_idx} :
    (reg_addr == ncis_pkg::REG_STATUS) ? {4'h0, power_control_reg[3], mem_bank_en, reg_bank_en, carry} :
    (reg_addr == ncis_pkg::REG_POWER_CONTROL_REG) ? {4'h0, power_control_reg} :
    (reg_addr == ncis_pkg::REG_PCL) ? pc[7:0] :
    (reg_addr == ncis_pkg::REG_PCH) ? {3'h0, pc[12:8]} :
    (reg_addr == ncis_pkg::REG_SP) ? sp :
    (reg_addr == ncis_pkg::REG_BANK) ? {2'h0, reg_bank, mem_bank} : 8'h00;

  assign stop_mode = power_control_reg[ncis_pkg::POWER_CONTROL_REG_STOP_BIT];

  // Machine cycle divider, restarted by every fetch so cycle counts stay exact
  always_ff @(posedge ref_clk) begin
    if (!resetn || state == ncis_pkg::ST_FETCH) begin
      mc_div <= ncis_pkg::MC_FIRST;
      cyc_cnt <= 2'h0;
    end else begin
      mc_div <= mc_tick ? 5'h00 : 5'(mc_div + 5'h01);
      cyc_cnt <= mc_tick ? 2'(cyc_cnt + 2'h1) : cyc_cnt;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      rd_ram_q <= 1'b0;
      rd_power_control_reg_q <= 1'b0;
    end else begin
      rd_ram_q <= ram_hit;
      rd_power_control_reg_q <= power_control_reg_hit;
    end
  end

  // Stop request wins over a clearing write in the same cycle
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      power_control_reg <= ncis_pkg::POWER_CONTROL_REG_RESET;
    end else if (exec_stop) begin
      power_control_reg[ncis_pkg::POWER_CONTROL_REG_STOP_BIT] <= 1'b1;
    end else if (sw_power_control_reg_wr) begin
      power_control_reg <= reg_wdata[3:0];
    end else if (wr_now && power_control_reg_hit) begin
      power_control_reg <= w[k[1:0]];
    end else if (state == ncis_pkg::ST_STOP && vreq_pend) begin
      power_control_reg[ncis_pkg::POWER_CONTROL_REG_STOP_BIT] <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      hold <= 1'b0;
      vreq_pend <= 1'b0;
      vreq_idx <= 3'h0;
      reg_rdata <= 8'h00;
    end else begin
      hold <= sw_ctrl_wr ? reg_wdata[0] : hold;
      vreq_pend <= sw_vreq_wr || (vreq_pend && !take_irq);
      vreq_idx <= sw_vreq_wr ? reg_wdata[2:0] : vreq_idx;
      reg_rdata <= reg_rd ? reg_rd_val : 8'h00;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      state <= ncis_pkg::ST_VEC0;
      pm_ret <= ncis_pkg::ST_FETCH;
      vec_idx <= ncis_pkg::VEC_RESET;
      vec_hi <= 8'h00;
      pc <= ncis_pkg::PC_RESET;
      sp <= ncis_pkg::SP_RESET;
      carry <= 1'b0;
      mem_bank_en <= 1'b0;
      reg_bank_en <= 1'b0;
      mem_bank <= 4'h0;
      reg_bank <= 2'h0;
      skip <= 1'b0;
      op1 <= 8'h00;
      op2 <= 8'h00;
      k <= 3'h0;
      wmask <= 4'h0;
      need <= 2'h1;
      pm_addr <= 13'h0000;
      pm_rd <= 1'b0;
      for (int i = 0; i < 6; i++) begin
        t[i] <= 4'h0;
      end
      for (int i = 0; i < 4; i++) begin
        w[i] <= 4'h0;
      end
    end else begin
      pm_rd <= 1'b0;
      case (state)
        ncis_pkg::ST_VEC0: begin
          pm_addr <= {9'h000, vec_idx, 1'b0};
          pm_rd <= 1'b1;
          pm_ret <= ncis_pkg::ST_VEC1;
          state <= ncis_pkg::ST_PMW;
        end
        ncis_pkg::ST_VEC1: begin
          vec_hi <= pm_data;
          pm_addr <= {9'h000, vec_idx, 1'b1};
          pm_rd <= 1'b1;
          pm_ret <= ncis_pkg::ST_VEC2;
          state <= ncis_pkg::ST_PMW;
        end
        ncis_pkg::ST_VEC2: begin
          pc <= {vec_hi[4], vec_hi[3:0], pm_data};
          mem_bank_en <= vec_hi[7];
          reg_bank_en <= vec_hi[6];
          state <= ncis_pkg::ST_FETCH;
        end
        ncis_pkg::ST_PMW: begin
          state <= pm_ret;
        end
        ncis_pkg::ST_PUSH: begin
          k <= 3'(k + 3'h1);
          if (k == 3'h5) begin
            sp <= 8'(sp - ncis_pkg::FRAME_NIBS);
            vec_idx <= vreq_idx;
            state <= ncis_pkg::ST_VEC0;
          end
        end
        ncis_pkg::ST_FETCH: begin
          k <= 3'h0;
          if (take_irq) begin
            state <= ncis_pkg::ST_PUSH;
          end else if (!hold) begin
            pm_addr <= pc;
            pm_rd <= 1'b1;
            pc <= 13'(pc + 13'h0001);
            pm_ret <= ncis_pkg::ST_OP1;
            state <= ncis_pkg::ST_PMW;
          end
        end
        ncis_pkg::ST_OP1: begin
          op1 <= pm_data;
          op2 <= 8'h00;
          if (two_byte_in) begin
            pm_addr <= pc;
            pm_rd <= 1'b1;
            pc <= 13'(pc + 13'h0001);
            pm_ret <= ncis_pkg::ST_OP2;
            state <= ncis_pkg::ST_PMW;
          end else begin
            state <= ncis_pkg::ST_DEC;
          end
        end
        ncis_pkg::ST_OP2: begin
          op2 <= pm_data;
          state <= ncis_pkg::ST_DEC;
        end
        ncis_pkg::ST_DEC: begin
          need <= cyc_need;
          if (skip) begin
            skip <= 1'b0;
            state <= ncis_pkg::ST_WAIT;
          end else begin
            state <= ncis_pkg::ST_READ;
          end
        end
        ncis_pkg::ST_READ: begin
          if (k != 3'h0) begin
            t[3'(k - 3'h1)] <= rd_data;
          end
          k <= 3'(k + 3'h1);
          if (k == 3'h6) begin
            state <= ncis_pkg::ST_EXEC;
          end
        end
        ncis_pkg::ST_EXEC: begin
          k <= 3'h0;
          wmask <= 4'h0;
          state <= ncis_pkg::ST_WRITE;
          case (cls)
            ncis_pkg::CLS_SBS_AM: begin
              w[0] <= diff_am[3:0];
              wmask <= 4'h1;
              skip <= diff_am[4];
            end
            ncis_pkg::CLS_SBS_EARR: begin
              w[0] <= diff_earr[3:0];
              w[1] <= diff_earr[7:4];
              wmask <= 4'h3;
              skip <= diff_earr[8];
            end
            ncis_pkg::CLS_SBS_RREA: begin
              w[2] <= diff_rrea[3:0];
              w[3] <= diff_rrea[7:4];
              wmask <= 4'hC;
              skip <= diff_rrea[8];
            end
            ncis_pkg::CLS_XCH_AR: begin
              w[0] <= t[4];
              w[2] <= t[2];
              wmask <= 4'h5;
            end
            ncis_pkg::CLS_XCH_EAHL: begin
              w[0] <= t[4];
              w[1] <= t[5];
              w[2] <= t[2];
              w[3] <= t[3];
              wmask <= 4'hF;
            end
            ncis_pkg::CLS_SCF: begin
              carry <= 1'b1;
            end
            ncis_pkg::CLS_SMB: begin
              mem_bank <= op2[3:0];
            end
            ncis_pkg::CLS_SRB: begin
              reg_bank <= op2[1:0];
            end
            ncis_pkg::CLS_RET, ncis_pkg::CLS_RETURN_AND_SKIP_OP, ncis_pkg::CLS_INTERRUPT_RETURN_OP: begin
              pc[11:0] <= {t[0], t[3], t[2]};
              mem_bank_en <= t[4][1];
              reg_bank_en <= t[4][0];
              sp <= 8'(sp + ncis_pkg::FRAME_NIBS);
              skip <= cls == ncis_pkg::CLS_RETURN_AND_SKIP_OP;
            end
            default: begin
            end
          endcase
        end
        ncis_pkg::ST_WRITE: begin
          k <= 3'(k + 3'h1);
          if (k == 3'h3) begin
            state <= ncis_pkg::ST_WAIT;
          end
        end
        ncis_pkg::ST_WAIT: begin
          if (wait_done) begin
            state <= stop_mode ? ncis_pkg::ST_STOP : ncis_pkg::ST_FETCH;
          end
        end
        ncis_pkg::ST_STOP: begin
          // Frozen until the stop bit drops; the program supplies settling no-ops
          if (!stop_mode) begin
            state <= ncis_pkg::ST_FETCH;
          end
        end
        default: begin
          state <= ncis_pkg::ST_FETCH;
        end
      endcase
    end
  end
endmodule

// >>> core/ncis_pkg.sv
// Shared constants, opcodes and types of the nibble core subset
package ncis_pkg;
  localparam int MC_CLKS = 32;
  localparam logic [4:0] MC_FIRST = 5'h01;
  localparam logic [4:0] MC_LAST = 5'(MC_CLKS - 1);
  localparam int RAM_AW = 9;
  localparam int RAM_DEPTH = 512;
  localparam logic [11:0] POWER_CONTROL_REG_ADDR = 12'hFB3;
  localparam int POWER_CONTROL_REG_STOP_BIT = 3;
  localparam logic [3:0] POWER_CONTROL_REG_RESET = 4'h0;
  localparam logic [7:0] SP_RESET = 8'h00;
  localparam logic [7:0] FRAME_NIBS = 8'h06;
  localparam logic [2:0] VEC_RESET = 3'h0;
  localparam logic [12:0] PC_RESET = 13'h0000;
  // Working register slots inside one bank
  localparam logic [2:0] RI_A = 3'h0;
  localparam logic [2:0] RI_E = 3'h1;
  localparam logic [2:0] RI_L = 3'h2;
  localparam logic [2:0] RI_H = 3'h3;
  // Software port offsets
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_VREQ = 4'h1;
  localparam logic [3:0] REG_STATUS = 4'h2;
  localparam logic [3:0] REG_POWER_CONTROL_REG = 4'h3;
  localparam logic [3:0] REG_PCL = 4'h4;
  localparam logic [3:0] REG_PCH = 4'h5;
  localparam logic [3:0] REG_SP = 4'h6;
  localparam logic [3:0] REG_BANK = 4'h7;
  // Opcodes
  localparam logic [7:0] OP_SBS_AM = 8'h3D;
  localparam logic [7:0] OP_PFX_DC = 8'hDC;
  localparam logic [7:0] OP_PFX_DD = 8'hDD;
  localparam logic [7:0] OP_PFX_FF = 8'hFF;
  localparam logic [7:0] OP_SCF = 8'hE7;
  localparam logic [7:0] OP_RETURN_AND_SKIP_OP = 8'hE5;
  localparam logic [7:0] OP_RET = 8'hC5;
  localparam logic [7:0] OP_INTERRUPT_RETURN_OP = 8'hD5;
  localparam logic [7:0] OP2_STOP = 8'hB3;
  localparam logic [7:0] OP2_XCH_EAHL = 8'h01;
  localparam logic [3:0] OP2_SMB_HI = 4'h4;
  localparam logic [5:0] OP2_SRB_HI = 6'h14;
  localparam logic [4:0] OP2_SBS_EARR = 5'h17;
  localparam logic [4:0] OP2_SBS_RREA = 5'h16;
  localparam logic [4:0] OP_XCH_AR_HI = 5'h0D;

  typedef enum logic [3:0] {
    ST_VEC0, ST_VEC1, ST_VEC2, ST_PMW, ST_PUSH, ST_FETCH, ST_OP1, ST_OP2,
    ST_DEC, ST_READ, ST_EXEC, ST_WRITE, ST_WAIT, ST_STOP
  } ncis_state_type;

  typedef enum logic [3:0] {
    CLS_NOP, CLS_SBS_AM, CLS_SBS_EARR, CLS_SBS_RREA, CLS_SCF, CLS_SMB, CLS_SRB,
    CLS_RET, CLS_RETURN_AND_SKIP_OP, CLS_INTERRUPT_RETURN_OP, CLS_STOP, CLS_XCH_AR, CLS_XCH_EAHL
  } ncis_cls_type;

  typedef enum logic [1:0] {
    SRC_HL, SRC_PAIR, SRC_REG
  } ncis_src_type;
endpackage

// >>> core/ncis_ram_if.sv
// Data memory port between the core and its nibble memory
`timescale 1ns/1ps
interface ncis_ram_if;
  logic [ncis_pkg::RAM_AW-1:0] addr;
  logic [3:0] wdata;
  logic we;
  logic [3:0] rdata;
  modport core (output addr, output wdata, output we, input rdata);
  modport mem (input addr, input wdata, input we, output rdata);
endinterface

// >>> core/ncis_ram.sv
// Nibble-wide data memory with registered read data
`timescale 1ns/1ps
module ncis_ram (
  input wire logic ref_clk,
  input wire logic resetn,
  ncis_ram_if.mem bus
);
  logic [3:0] mem [0:ncis_pkg::RAM_DEPTH-1];

  always_ff @(posedge ref_clk) begin
    if (bus.we) begin
      mem[bus.addr] <= bus.wdata;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      bus.rdata <= 4'h0;
    end else begin
      bus.rdata <= mem[bus.addr];
    end
  end
endmodule

// >>> tb/ncis_core_monitor.sv
// Port-level assertions for the nibble core
`timescale 1ns/1ps
module ncis_core_monitor (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic [12:0] pm_addr,
  input wire logic pm_rd,
  input wire logic [7:0] pm_data,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic stop_mode
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);

  reset_quiet_a: assert property (disable iff (1'b0) !resetn |=> !pm_rd && !stop_mode
    && pm_addr == 13'h0000 && reg_rdata == 8'h00) else $error("outputs not cleared in reset");
  reset_vec_a: assert property ($rose(resetn) |-> ##[0:8] (pm_rd && pm_addr == 13'h0000))
    else $error("no vector fetch after reset");
  vec_pair_a: assert property (pm_rd && pm_addr == 13'h0000 |-> ##2 (pm_rd &&
    pm_addr == 13'h0001)) else $error("vector entry bytes out of order");
  stop_halt_a: assert property (stop_mode |-> !pm_rd)
    else $error("fetch while stopped");
  stop_status_a: assert property (reg_rd && (reg_addr == ncis_pkg::REG_STATUS ||
    reg_addr == ncis_pkg::REG_POWER_CONTROL_REG) |=> reg_rdata[3] == $past(stop_mode)
    && reg_rdata[7:4] == 4'h0) else $error("stop bit read back wrong");
  power_control_reg_wake_a: assert property (stop_mode && reg_wr && reg_addr == ncis_pkg::REG_POWER_CONTROL_REG
    && !reg_wdata[3] |=> !stop_mode) else $error("stop bit not cleared by write");
  rdata_idle_a: assert property (!reg_rd |=> reg_rdata == 8'h00)
    else $error("read data outside read answer");
  fetch_pulse_a: assert property (pm_rd |=> !pm_rd && $stable(pm_addr))
    else $error("fetch strobe longer than one cycle");
endmodule

// >>> tb/ncis_pmem_model.sv
// Program memory partner: registered byte read, scrambled when idle
`timescale 1ns/1ps
module ncis_pmem_model (
  input wire logic ref_clk,
  input wire logic [12:0] pm_addr,
  input wire logic pm_rd,
  output logic [7:0] pm_data
);
  logic [7:0] mem [0:8191];

  initial begin
    pm_data = 8'h5A;
    for (int i = 0; i < 8192; i++) begin
      mem[i] = 8'h00;
    end
  end

  // Byte stands one cycle only, so a late capture sees junk
  always @(posedge ref_clk) begin
    if (pm_rd) begin
      pm_data <= mem[pm_addr];
    end else begin
      pm_data <= ~pm_data;
    end
  end
endmodule

// >>> tb/tb_nibble_cpu_insn_subset.sv
// Self-checking bench for the nibble core instruction subset
`timescale 1ns/1ps
module tb_nibble_cpu_insn_subset;
  logic ref_clk;
  logic resetn;
  logic [12:0] pm_addr;
  logic pm_rd;
  logic [7:0] pm_data;
  logic [3:0] reg_addr;
  logic [7:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [7:0] reg_rdata;
  logic stop_mode;
  int err_total;
  int checks;
  int cyc;
  int last_fetch;
  logic rd_d1;
  logic [7:0] exp_q[$];
  string name_q[$];
  logic [12:0] fa_q[$];
  int fg_q[$];
  // Fetch order and clocks since the previous fetch, 0 = not timed
  // Second byte of a pair (vector or operand) follows its first after 2 clocks
  int fa_tab [22] = '{'h0, 'h1, 'h10, 'h11, 'h12, 'h13, 'h14, 'h15, 'h16, 'h17, 'h2, 'h3,
    'h40, 'h18, 'h19, 'h1A, 'h1B, 'h1C, 'h1D, 'h1E, 'h1F, 'h20};
  int fg_tab [22] = '{0, 2, 0, 32, 2, 62, 2, 62, 32, 2, 0, 2, 0, 96, 32, 32, 32, 2, 62, 32, 2,
    62};

  ncis_core dut (.ref_clk(ref_clk), .resetn(resetn), .pm_addr(pm_addr), .pm_rd(pm_rd),
    .pm_data(pm_data), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .stop_mode(stop_mode));
  ncis_pmem_model pm (.ref_clk(ref_clk), .pm_addr(pm_addr), .pm_rd(pm_rd), .pm_data(pm_data));

  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end

  task automatic check(input string what, input logic [12:0] seen, input logic [12:0] exp);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic final_report();
    $display("Comparisons %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    @(posedge ref_clk);
  endtask

  task automatic rd(input logic [3:0] a, input logic [7:0] e, input string what);
    reg_addr <= a;
    reg_rd <= 1'b1;
    exp_q.push_back(e);
    name_q.push_back(what);
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    @(posedge ref_clk);
  endtask

  task automatic await(input int kind);
    int n;
    n = 0;
    while (!((kind == 0 && stop_mode === 1'b1) || (kind == 1 && fa_q.size() == 0))) begin
      @(posedge ref_clk);
      n++;
      if (n > 4000) begin
        err_total++;
        $display("BAD wait %0d expected done seen timeout", kind);
        final_report();
      end
    end
  endtask

  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    rd_d1 <= reg_rd;
    // Read data stand only in the cycle after the strobe
    if (rd_d1 && exp_q.size() > 0) begin
      check(name_q.pop_front(), 13'(reg_rdata), 13'(exp_q.pop_front()));
    end
    if (pm_rd === 1'b1 && fa_q.size() > 0) begin
      check("fetch address", pm_addr, fa_q.pop_front());
      if (fg_q[0] != 0) begin
        check("fetch spacing", 13'(cyc - last_fetch), 13'(fg_q[0]));
      end
      void'(fg_q.pop_front());
      last_fetch <= cyc;
    end
  end

  initial begin
    void'($urandom(32'h5437));
    resetn = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    rd_d1 = 1'b0;
    cyc = 0;
    last_fetch = 0;
    foreach (fa_tab[i]) begin
      fa_q.push_back(13'(fa_tab[i]));
      fg_q.push_back(fg_tab[i]);
    end
    @(posedge ref_clk);
    // Vectors: reset -> 010 with both enables, request 1 -> 040 with none
    pm.mem[0] = 8'hC0;
    pm.mem[1] = 8'h10;
    pm.mem[3] = 8'h40;
    pm.mem['h10] = 8'hE7;
    {pm.mem['h11], pm.mem['h12], pm.mem['h13], pm.mem['h14]} = 32'hDD4F_DD53;
    pm.mem['h15] = 8'h69;
    {pm.mem['h16], pm.mem['h17]} = 16'hFFB3;
    // Three idle bytes follow the stop, then a bank 0 select
    {pm.mem['h1B], pm.mem['h1C]} = 16'hDD40;
    pm.mem['h40] = 8'hE5;
    // Borrowing subtract; its skip target is a bank select, so a lost skip shows in BANK
    {pm.mem['h1D], pm.mem['h1E], pm.mem['h1F]} = 24'h3DDD4F;
    // Bank 3 registers A 7, E 2, L 0, H 2; the exchange swaps A and E first
    dut.u_ram.mem['h18] = 4'h7;
    dut.u_ram.mem['h19] = 4'h2;
    dut.u_ram.mem['h1A] = 4'h0;
    dut.u_ram.mem['h1B] = 4'h2;
    dut.u_ram.mem['h20] = 4'h5;
    repeat (5) @(posedge ref_clk);
    resetn <= 1'b1;
    await(0);
    repeat (40) @(posedge ref_clk);
    rd(ncis_pkg::REG_STATUS, 8'h0F, "status in stop");
    rd(ncis_pkg::REG_POWER_CONTROL_REG, 8'h08, "power control");
    rd(ncis_pkg::REG_BANK, 8'h3F, "bank select");
    rd(ncis_pkg::REG_SP, 8'h00, "stack pointer");
    // Hold first so the wake and the request meet the same fetch
    wr(ncis_pkg::REG_CTRL, 8'h01);
    wr(ncis_pkg::REG_POWER_CONTROL_REG, 8'h00);
    wr(ncis_pkg::REG_VREQ, 8'h01);
    wr(ncis_pkg::REG_CTRL, 8'h00);
    await(1);
    wr(ncis_pkg::REG_CTRL, 8'h01);
    repeat (100) @(posedge ref_clk);
    check("subtract result", 13'(dut.u_ram.mem['h18]), 13'h000D);
    check("exchanged register", 13'(dut.u_ram.mem['h19]), 13'h0007);
    check("subtract source", 13'(dut.u_ram.mem['h20]), 13'h0005);
    rd(ncis_pkg::REG_STATUS, 8'h07, "status after return");
    rd(ncis_pkg::REG_BANK, 8'h30, "bank after return");
    rd(ncis_pkg::REG_SP, 8'h00, "stack after return");
    rd(4'h8 | 4'($urandom_range(7, 0)), 8'h00, "unmapped read");
    wr(ncis_pkg::REG_STATUS, 8'($urandom()));
    rd(ncis_pkg::REG_STATUS, 8'h07, "status read only");
    repeat (4) @(posedge ref_clk);
    final_report();
  end
endmodule

bind ncis_core ncis_core_monitor mon (.ref_clk(ref_clk), .resetn(resetn), .pm_addr(pm_addr),
  .pm_rd(pm_rd), .pm_data(pm_data), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .stop_mode(stop_mode));
